//--- logic/scd_pkg.sv
package scd_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned SCD_CLK_PERIOD_NS = 40;
    // straps must settle this long after reset release before capture
    localparam int unsigned SCD_SETTLE_NS = 10000;
    localparam int unsigned SCD_SETTLE_CYC =
        (SCD_SETTLE_NS + SCD_CLK_PERIOD_NS - 1) / SCD_CLK_PERIOD_NS;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam int unsigned SCD_ADDR_W = 5;
    localparam logic [SCD_ADDR_W-1:0] SCD_OFS_CTRL = 5'h00;
    localparam logic [SCD_ADDR_W-1:0] SCD_OFS_STRAP = 5'h04;
    localparam logic [SCD_ADDR_W-1:0] SCD_OFS_IRQ_STAT = 5'h08;
    localparam logic [SCD_ADDR_W-1:0] SCD_OFS_IRQ_CLR = 5'h0c;
    localparam logic [SCD_ADDR_W-1:0] SCD_OFS_IRQ_EN = 5'h10;

    // ctrl fields
    localparam int unsigned SCD_CTRL_W = 2;
    localparam int unsigned SCD_CTRL_DIAG_DONE = 0;
    localparam int unsigned SCD_CTRL_FORCE_FAULT = 1;
    localparam logic [SCD_CTRL_W-1:0] SCD_CTRL_RST = 2'h0;

    // strap status fields
    localparam int unsigned SCD_ST_ID = 0;
    localparam int unsigned SCD_ST_FORCE_SE = 4;
    localparam int unsigned SCD_ST_WP = 5;
    localparam int unsigned SCD_ST_ERASE = 6;
    localparam int unsigned SCD_ST_TERMPWR = 7;
    localparam int unsigned SCD_ST_ACT_SEL = 8;
    localparam int unsigned SCD_ST_TERM = 9;
    localparam int unsigned SCD_ST_LATCHED = 10;
    localparam int unsigned SCD_ST_SE_MODE = 11;
    localparam int unsigned SCD_ST_ERASE_ACT = 12;

    // interrupt fields, shared by status, clear and enable
    localparam int unsigned SCD_IRQ_W = 4;
    localparam int unsigned SCD_IRQ_LATCHED = 0;
    localparam int unsigned SCD_IRQ_ERASE_DONE = 1;
    localparam int unsigned SCD_IRQ_FAULT = 2;
    localparam int unsigned SCD_IRQ_MODE = 3;
    localparam logic [SCD_IRQ_W-1:0] SCD_IRQ_RST = 4'h0;

    localparam logic [31:0] SCD_RDATA_RST = 32'h0000_0000;

    // ************************************************************
    // strap carriers, 1 = jumper fitted unless named _n
    // ************************************************************
    typedef struct packed {
        logic act_sel;
        logic termpwr;
        logic erase;
        logic wp;
        logic force_se;
        logic term;
        logic [3:0] id;
    } scd_hdr_t;

    typedef struct packed {
        logic wp_n;
        logic term_n;
        logic [3:0] id;
    } scd_aux_t;

    typedef struct packed {
        scd_aux_t aux;
        scd_hdr_t hdr;
    } scd_straps_t;

    localparam int unsigned SCD_STRAP_W = $bits(scd_straps_t);

    // decoded configuration
    typedef struct packed {
        logic force_se;
        logic wp;
        logic erase;
        logic term_en;
        logic termpwr_en;
        logic act_sel;
        logic [3:0] bus_id;
    } scd_cfg_t;

    localparam scd_cfg_t SCD_CFG_RST = '0;

endpackage

//--- logic/scd_strap_latch.sv
`timescale 1ns/100ps

module scd_strap_latch import scd_pkg::*; #(
    parameter int unsigned WIDTH = SCD_STRAP_W,
    parameter int unsigned SETTLE_CYC = SCD_SETTLE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] data_out,
    output logic valid_out
);

    localparam int unsigned CW = $clog2(SETTLE_CYC + 1);

    if (WIDTH < 1 || SETTLE_CYC < 1) begin : g_bad_param
        $error("scd_strap_latch needs WIDTH and SETTLE_CYC of at least one");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
        logic [WIDTH-1:0] data;
    } scd_latch_st_t;

    scd_latch_st_t s_q;
    scd_latch_st_t s_d;

    // ************************************************************
    // single capture after settle time, then frozen until reset
    // ************************************************************
    always_comb begin
        s_d = s_q;
        if (!s_q.done) begin
            if (s_q.cnt == CW'(SETTLE_CYC - 1)) begin
                s_d.data = raw_in;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.data;
    assign valid_out = s_q.done;

endmodule

//--- logic/scd_strap_cfg.sv
// Chosen here: register access over Avalon-MM and the address map.
`timescale 1ns/100ps

module scd_strap_cfg import scd_pkg::*; #(
    parameter int unsigned SETTLE_CYC = SCD_SETTLE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // straps, synchronous to the clock
    input wire scd_hdr_t hdr_strap_in,
    input wire scd_aux_t aux_strap_in,
    // status from the rest of the drive
    input wire logic bus_lvd_detect_in,
    input wire logic fault_in,
    input wire logic cmd_active_in,
    input wire logic erase_done_in,
    // configuration to the rest of the drive
    output logic se_mode_out,
    output logic write_protect_out,
    output logic erase_start_out,
    output logic erase_active_out,
    output logic term_en_out,
    output logic termpwr_en_out,
    output logic act_led_sel_out,
    output logic [3:0] bus_id_out,
    output logic cfg_valid_out,
    // open-drain fault and busy LED pins, sink when enabled; act LED driven directly, no enable
    output logic fault_led_out,
    output logic fault_led_oe_out,
    output logic busy_led_out,
    output logic busy_led_oe_out,
    output logic act_led_out,
    // avalon-mm slave
    input wire logic [SCD_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out
);

    if (SETTLE_CYC < 1) begin : g_bad_param
        $error("scd_strap_cfg needs SETTLE_CYC of at least one");
    end

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [SCD_CTRL_W-1:0] ctrl;
        logic [SCD_IRQ_W-1:0] irq_stat;
        logic [SCD_IRQ_W-1:0] irq_en;
        logic irq;
        logic applied;
        scd_cfg_t cfg;
        logic se_mode;
        logic wp_eff;
        logic erase_start;
        logic erase_active;
        logic fault_led;
        logic busy_led;
        logic act_led;
        logic fault_prev;
    } scd_state_t;

    scd_state_t s_q;
    scd_state_t s_d;

    scd_straps_t raw;
    scd_straps_t lat;
    logic lat_valid;

    // ************************************************************
    // strap capture
    // ************************************************************
    assign raw.hdr = hdr_strap_in;
    assign raw.aux = aux_strap_in;

    scd_strap_latch #(
        .WIDTH(SCD_STRAP_W),
        .SETTLE_CYC(SETTLE_CYC)
    ) u_latch (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .raw_in(raw),
        .data_out(lat),
        .valid_out(lat_valid)
    );

    // ************************************************************
    // strap decode
    // ************************************************************
    scd_cfg_t dec;

    always_comb begin
        dec = SCD_CFG_RST;
        dec.force_se = lat.hdr.force_se;
        dec.wp = lat.hdr.wp | ~lat.aux.wp_n;
        dec.erase = lat.hdr.erase;
        dec.term_en = lat.hdr.term | ~lat.aux.term_n;
        dec.termpwr_en = lat.hdr.termpwr;
        dec.act_sel = lat.hdr.act_sel;
        dec.bus_id = lat.hdr.id | lat.aux.id;
    end

    // ************************************************************
    // bus access decode
    // ************************************************************
    logic req;
    logic fire;
    logic wr_fire;
    logic [31:0] rd_mux;
    logic [SCD_IRQ_W-1:0] irq_clr;
    logic [SCD_IRQ_W-1:0] irq_set;
    logic diag;
    logic se_next;

    assign req = avs_read_in | avs_write_in;
    // a transfer completes on the edge where waitrequest is low
    assign fire = req & ~s_q.waitreq;
    assign wr_fire = fire & avs_write_in & avs_byteenable_in[0];
    assign diag = ~s_q.ctrl[SCD_CTRL_DIAG_DONE];

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address_in)
            SCD_OFS_CTRL: begin
                rd_mux[SCD_CTRL_W-1:0] = s_q.ctrl;
            end
            SCD_OFS_STRAP: begin
                rd_mux[SCD_ST_ID +: 4] = s_q.cfg.bus_id;
                rd_mux[SCD_ST_FORCE_SE] = s_q.cfg.force_se;
                rd_mux[SCD_ST_WP] = s_q.cfg.wp;
                rd_mux[SCD_ST_ERASE] = s_q.cfg.erase;
                rd_mux[SCD_ST_TERMPWR] = s_q.cfg.termpwr_en;
                rd_mux[SCD_ST_ACT_SEL] = s_q.cfg.act_sel;
                rd_mux[SCD_ST_TERM] = s_q.cfg.term_en;
                rd_mux[SCD_ST_LATCHED] = s_q.applied;
                rd_mux[SCD_ST_SE_MODE] = s_q.se_mode;
                rd_mux[SCD_ST_ERASE_ACT] = s_q.erase_active;
            end
            SCD_OFS_IRQ_STAT: begin
                rd_mux[SCD_IRQ_W-1:0] = s_q.irq_stat;
            end
            SCD_OFS_IRQ_EN: begin
                rd_mux[SCD_IRQ_W-1:0] = s_q.irq_en;
            end
            default: begin
                // clear register and unmapped addresses read zero
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        irq_clr = '0;
        if (wr_fire && avs_address_in == SCD_OFS_IRQ_CLR) begin
            irq_clr = avs_writedata_in[SCD_IRQ_W-1:0];
        end
    end

    // ************************************************************
    // mode select, events
    // ************************************************************
    always_comb begin
        if (!s_q.applied) begin
            se_next = 1'b1;
        end else if (s_q.cfg.force_se) begin
            se_next = 1'b1;
        end else begin
            se_next = ~bus_lvd_detect_in;
        end
    end

    always_comb begin
        irq_set = '0;
        irq_set[SCD_IRQ_LATCHED] = lat_valid & ~s_q.applied;
        irq_set[SCD_IRQ_ERASE_DONE] = s_q.erase_active & erase_done_in;
        irq_set[SCD_IRQ_FAULT] = fault_in & ~s_q.fault_prev;
        irq_set[SCD_IRQ_MODE] = s_q.applied & (se_next != s_q.se_mode);
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;

        // answer one cycle after the request appears
        s_d.waitreq = 1'b1;
        if (req && s_q.waitreq) begin
            s_d.waitreq = 1'b0;
            s_d.rdata = avs_read_in ? rd_mux : 32'h0000_0000;
        end

        if (wr_fire && avs_address_in == SCD_OFS_CTRL) begin
            s_d.ctrl = avs_writedata_in[SCD_CTRL_W-1:0];
        end
        if (wr_fire && avs_address_in == SCD_OFS_IRQ_EN) begin
            s_d.irq_en = avs_writedata_in[SCD_IRQ_W-1:0];
        end

        // a new event wins over a clear in the same cycle
        s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
        s_d.irq = |(s_d.irq_stat & s_d.irq_en);

        // decoded straps taken exactly once
        s_d.erase_start = 1'b0;
        if (lat_valid && !s_q.applied) begin
            s_d.applied = 1'b1;
            s_d.cfg = dec;
            // erase is not gated by write protection
            s_d.erase_start = dec.erase;
            s_d.erase_active = dec.erase;
        end else if (s_q.erase_active && erase_done_in) begin
            s_d.erase_active = 1'b0;
        end

        s_d.se_mode = se_next;
        s_d.wp_eff = s_q.applied & s_q.cfg.wp;

        // LED pins are separate drivers, never paused to read the ID jumper
        s_d.fault_led = diag | fault_in | s_q.ctrl[SCD_CTRL_FORCE_FAULT];
        s_d.busy_led = diag | cmd_active_in;
        s_d.act_led = s_q.applied & s_q.cfg.act_sel & (diag | cmd_active_in);
        s_d.fault_prev = fault_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            s_q.waitreq <= 1'b1;
            s_q.rdata <= SCD_RDATA_RST;
            s_q.ctrl <= SCD_CTRL_RST;
            s_q.irq_stat <= SCD_IRQ_RST;
            s_q.irq_en <= SCD_IRQ_RST;
            s_q.irq <= 1'b0;
            s_q.applied <= 1'b0;
            s_q.cfg <= SCD_CFG_RST;
            s_q.se_mode <= 1'b1;
            s_q.wp_eff <= 1'b0;
            s_q.erase_start <= 1'b0;
            s_q.erase_active <= 1'b0;
            s_q.fault_led <= 1'b1;
            s_q.busy_led <= 1'b1;
            s_q.act_led <= 1'b0;
            s_q.fault_prev <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign se_mode_out = s_q.se_mode;
    assign write_protect_out = s_q.wp_eff;
    assign erase_start_out = s_q.erase_start;
    assign erase_active_out = s_q.erase_active;
    assign term_en_out = s_q.cfg.term_en;
    assign termpwr_en_out = s_q.cfg.termpwr_en;
    assign act_led_sel_out = s_q.cfg.act_sel;
    assign bus_id_out = s_q.cfg.bus_id;
    assign cfg_valid_out = s_q.applied;
    // open-drain: value is a constant low level, enable lights the LED
    assign fault_led_out = s_q.rdata[31] & 1'b0;
    assign fault_led_oe_out = s_q.fault_led;
    assign busy_led_out = s_q.rdata[31] & 1'b0;
    assign busy_led_oe_out = s_q.busy_led;
    assign act_led_out = s_q.act_led;
    assign avs_readdata_out = s_q.rdata;
    assign avs_waitrequest_out = s_q.waitreq;
    assign irq_out = s_q.irq;

endmodule

//--- verif/scd_asserts.sv
`timescale 1ns/100ps

module scd_asserts import scd_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire scd_hdr_t hdr_strap_in,
    input wire scd_aux_t aux_strap_in,
    input wire logic fault_in,
    input wire logic cmd_active_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic avs_waitrequest_out,
    input wire logic cfg_valid_out,
    input wire logic [3:0] bus_id_out,
    input wire logic term_en_out,
    input wire logic termpwr_en_out,
    input wire logic write_protect_out,
    input wire logic erase_start_out,
    input wire logic se_mode_out,
    input wire logic fault_led_oe_out,
    input wire logic busy_led_oe_out
);
    // ****************************************
    // strap capture, bus handshake and LED checks
    // ****************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    // config becomes visible two edges after the straps were sampled
    sequence s_cap;
        $rose(cfg_valid_out);
    endsequence

    sequence s_cap_forced;
        s_cap ##0 $past(hdr_strap_in.force_se, 2);
    endsequence

    AST_WAIT_ANSWER: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus request not answered one cycle after it was seen");
    AST_WAIT_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    AST_BUS_ID: assert property (
        s_cap |-> bus_id_out == ($past(hdr_strap_in.id, 2) | $past(aux_strap_in.id, 2)))
        else $error("bus id differs from ored straps");
    AST_TERM: assert property (
        s_cap |-> term_en_out == ($past(hdr_strap_in.term, 2) | !$past(aux_strap_in.term_n, 2)))
        else $error("termination enable differs from straps");
    AST_TPWR_ERASE: assert property (
        s_cap |-> termpwr_en_out == $past(hdr_strap_in.termpwr, 2)
        && erase_start_out == $past(hdr_strap_in.erase, 2))
        else $error("termination power or erase start differs from straps");
    AST_WPROT: assert property (
        s_cap |=> write_protect_out == ($past(hdr_strap_in.wp, 3) | !$past(aux_strap_in.wp_n, 3)))
        else $error("write protect differs from straps");
    AST_FORCE_SE: assert property (s_cap_forced |=> se_mode_out [*4])
        else $error("forced single-ended mode not held");
    AST_HOLD: assert property (
        cfg_valid_out |=> cfg_valid_out && $stable(bus_id_out) && $stable(term_en_out))
        else $error("configuration changed after capture");
    AST_FAULT_LED: assert property (fault_in |=> fault_led_oe_out)
        else $error("fault led not lit after internal fault");
    AST_BUSY_LED: assert property (cmd_active_in |=> busy_led_oe_out)
        else $error("busy led not lit while commands execute");
endmodule

bind scd_strap_cfg scd_asserts scd_asserts_inst (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .hdr_strap_in(hdr_strap_in),
    .aux_strap_in(aux_strap_in), .fault_in(fault_in), .cmd_active_in(cmd_active_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_waitrequest_out(avs_waitrequest_out), .cfg_valid_out(cfg_valid_out),
    .bus_id_out(bus_id_out), .term_en_out(term_en_out), .termpwr_en_out(termpwr_en_out),
    .write_protect_out(write_protect_out), .erase_start_out(erase_start_out),
    .se_mode_out(se_mode_out), .fault_led_oe_out(fault_led_oe_out),
    .busy_led_oe_out(busy_led_oe_out));

//--- verif/scd_jumpers.sv
`timescale 1ns/100ps

module scd_jumpers import scd_pkg::*; (
    input wire logic [9:0] hdr_fit_in,
    input wire logic [5:0] aux_fit_in,
    input wire logic fault_led_in,
    input wire logic fault_oe_in,
    input wire logic busy_led_in,
    input wire logic busy_oe_in,
    output scd_hdr_t hdr_strap_out,
    output scd_aux_t aux_strap_out,
    output logic fault_lit_out,
    output logic busy_lit_out
);
    // ****************************************
    // jumpers, remote switches and leds
    // ****************************************
    assign hdr_strap_out = hdr_fit_in;
    // remote switch grounds its pin, an open pin is pulled high
    assign aux_strap_out = {~aux_fit_in[5:4], aux_fit_in[3:0]};
    // led conducts only while the pin is sunk low
    assign fault_lit_out = fault_oe_in && !fault_led_in;
    assign busy_lit_out = busy_oe_in && !busy_led_in;
endmodule

//--- verif/testbench.sv
`timescale 1ns/100ps

module testbench import scd_pkg::*; ;
    // ****************************************
    // stimulus and design
    // ****************************************
    logic sys_clk_in = 1'h0;
    logic reset_n_in = 1'h0;
    logic [9:0] hfit = 10'h000;
    logic [5:0] afit = 6'h00;
    logic lvd = 1'h1, flt = 1'h0, cmd = 1'h0, edone = 1'h0, rd = 1'h0, wr = 1'h0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, q, rdat;
    scd_hdr_t hdr;
    scd_aux_t aux;
    logic se, wp, es, ea, te, tp, al, cv, fl, flo, bl, blo, act, irq, wq, flit, blit;
    logic [3:0] bid;
    int fails = 0, n_checks = 0, cyc = 0;

    scd_strap_cfg #(.SETTLE_CYC(4)) scd_strap_cfg_inst (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .hdr_strap_in(hdr),
        .aux_strap_in(aux), .bus_lvd_detect_in(lvd), .fault_in(flt), .cmd_active_in(cmd),
        .erase_done_in(edone), .se_mode_out(se), .write_protect_out(wp),
        .erase_start_out(es), .erase_active_out(ea), .term_en_out(te), .termpwr_en_out(tp),
        .act_led_sel_out(al), .bus_id_out(bid), .cfg_valid_out(cv), .fault_led_out(fl),
        .fault_led_oe_out(flo), .busy_led_out(bl), .busy_led_oe_out(blo), .act_led_out(act),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
        .irq_out(irq));

    scd_jumpers scd_jumpers_inst (
        .hdr_fit_in(hfit), .aux_fit_in(afit), .fault_led_in(fl), .fault_oe_in(flo),
        .busy_led_in(bl), .busy_oe_in(blo), .hdr_strap_out(hdr), .aux_strap_out(aux),
        .fault_lit_out(flit), .busy_lit_out(blit));

    initial forever #20 sys_clk_in = ~sys_clk_in;

    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask

    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (wq !== 1'h0 && n < 20);
        q = rdat;
        rd <= 1'h0;
        wr <= 1'h0;
        chk("bus answer", 32'h1, n < 20);
    endtask

    task restart(input logic [9:0] h, input logic [5:0] x);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        reset_n_in <= 1'h0;
        hfit <= h;
        afit <= x;
        repeat (3) @(posedge sys_clk_in);
        reset_n_in <= 1'h1;
        @(negedge sys_clk_in);
        chk("diag busy led", 1'h1, blit);
        while (cv !== 1'h1 && n < 50) begin
            @(negedge sys_clk_in);
            n++;
        end
        chk("cfg valid", 1'h1, cv);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task t_straps;
        logic [3:0] i;
        for (int k = 0; k < 16; k++) begin
            i = k[3:0];
            restart({i[0], i[3], i[2], i[2], i[1], i[0], i & 4'h5}, {i[3], i[1], i & 4'ha});
            chk("bus id", i, bid);
            chk("term", i[0] | i[1], te);
            chk("termpwr", i[3], tp);
            chk("erase start", i[2], es);
            chk("erase active", i[2], ea);
            chk("act sel", i[0], al);
            step(0);
            chk("write protect", i[2] | i[3], wp);
            chk("se mode", i[1], se);
        end
        $display("strap decode test done");
    endtask

    task t_regs;
        restart(10'h020, 6'h00);
        bus(1'h0, SCD_OFS_IRQ_STAT, 32'h0);
        chk("irq stat", 32'h1, q);
        chk("irq masked", 1'h0, irq);
        bus(1'h1, SCD_OFS_IRQ_EN, 32'h1);
        bus(1'h1, SCD_OFS_STRAP, 32'h0);
        chk("irq", 1'h1, irq);
        bus(1'h0, SCD_OFS_STRAP, 32'h0);
        chk("strap reg", 32'h0c10, q);
        bus(1'h1, SCD_OFS_IRQ_CLR, 32'h1);
        bus(1'h0, SCD_OFS_IRQ_STAT, 32'h0);
        chk("irq stat cleared", 32'h0, q);
        chk("irq cleared", 1'h0, irq);
        bus(1'h0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("register test done");
    endtask

    task t_leds;
        restart(10'h200, 6'h0f);
        chk("diag fault led", 1'h1, flit);
        bus(1'h1, SCD_OFS_CTRL, 32'h1);
        step(2);
        chk("fault led off", 1'h0, flit);
        chk("busy led off", 1'h0, blit);
        @(posedge sys_clk_in);
        cmd <= 1'h1;
        lvd <= 1'h0;
        hfit <= 10'h00f;
        afit <= 6'h30;
        step(1);
        chk("busy led", 1'h1, blit);
        chk("act led", 1'h1, act);
        chk("se follows bus", 1'h1, se);
        chk("id held", 4'hf, bid);
        chk("term held", 1'h0, te);
        @(posedge sys_clk_in);
        flt <= 1'h1;
        cmd <= 1'h0;
        step(1);
        chk("fault led", 1'h1, flit);
        chk("busy led idle", 1'h0, blit);
        @(posedge sys_clk_in);
        flt <= 1'h0;
        bus(1'h1, SCD_OFS_CTRL, 32'h3);
        step(1);
        chk("forced fault led", 1'h1, flit);
        $display("led test done");
    endtask

    task results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        t_straps();
        t_regs();
        t_leds();
        results();
    end
endmodule
